// *** core/nvm_port_defines.vh ***
// constants for the parallel programming port of the small controller
// assumes a single 125 MHz clock and synchronous programmer pins
`ifndef NVM_PORT_DEFINES_VH
`define NVM_PORT_DEFINES_VH

// clock rate and write time (least busy time after a write strobe)
`define CLK_MHZ 125
`define T_WRITE_NS 3700000
`define WRITE_CYCLES ((`T_WRITE_NS * `CLK_MHZ) / 1000)
`define TIMER_W 20

// action select codes on action_sel_1/action_sel_0
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3

// command bytes
`define CMD_NOP 8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WR_FUSE 8'h40
`define CMD_WR_LOCK 8'h20
`define CMD_WR_FLASH 8'h10
`define CMD_WR_EEPROM 8'h11
`define CMD_RD_SIG 8'h08
`define CMD_RD_FUSE 8'h04
`define CMD_RD_FLASH 8'h02
`define CMD_RD_EEPROM 8'h03

// memory geometry
`define FLASH_WORDS 1024
`define FLASH_AW 10
`define FLASH_PAGE_WORDS 16
`define FLASH_WORD_BITS 4
`define EE_BYTES 128
`define EE_AW 7
`define EE_PAGE_BYTES 4
`define EE_BYTE_BITS 2

// fifo entry: {to_eeprom, high_byte, index[3:0], data[7:0]}
`define ENTRY_W 14
`define FIFO_DEPTH 8
`define FIFO_AW 3

// reset values of the nonvolatile bytes and the signature area
`define FUSE_LOW_RST 8'h64
`define FUSE_HIGH_RST 8'hdf
`define FUSE_EXT_RST 8'hff
`define LOCK_RST 8'hff
`define BLANK_BYTE 8'hff
`define SIG_LAST 8'h02
`define CAL_ADDR 8'h00

`endif

// *** core/nvm_port.v ***
// parallel programming port: command/address/data loading, page buffers,
// flash/eeprom page writes, fuse and lock writes, and all read paths.
// assumes programmer pins are synchronous to clk and held for several cycles.
//
// Functional notes
// - load_strobe with action 10, bs1 low loads command
// - command 0x10 selects flash page writing
// - action 00, bs1 low loads address low byte
// - action 01 loads data low/high byte by bs1
// - action 00, bs1 high loads address high byte
// - low bits pick word, upper bits pick page
// - write strobe programs whole page, busy till done
// - command 0x00 clears write controls, ends session
// - command 0x11 writes eeprom page on strobe
// - command 0x02 reads flash low/high byte
// - command 0x03 reads eeprom byte at address
// - command 0x40 writes low fuse, zero programs
// - bs1 high, bs2 low writes high fuse
// - bs1 low, bs2 high writes extended fuse
// - command 0x20 programs locks; mode 3 freezes boot
// - lock bits never return to one here
// - command 0x04 reads fuses/locks by bs2/bs1
// - command 0x08 reads signature bytes 0 to 2
// - signature command, bs1 high reads calibration byte
// - data bus driven while output enable low, one cycle late
// - action 11 load changes nothing
// - ready_busy_out low while programming, else high
`include "nvm_port_defines.vh"
`default_nettype none

// small synchronous fifo, count based so full and empty are exact
module nvm_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst,
    input wire flush,
    input wire in_valid,
    output reg in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0] wr_ptr, rd_ptr;
    reg [AW:0] count;
    wire push, pop;
    wire [AW:0] next_count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data = store[rd_ptr];

    // storage has no reset; only pointers and flags matter
    always @(posedge clk) begin
        if (push) store[wr_ptr] <= in_data;
    end

    // pointers, count and the registered flags
    always @(posedge clk) begin
        if (rst || flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop) rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            count <= next_count;
            in_ready <= (next_count != DEPTH);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule

module nvm_port #(
    parameter WRITE_CYCLES = `WRITE_CYCLES,
    parameter [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
    parameter [7:0] SIG_BYTE1 = 8'ha5, // arbitrary value
    parameter [7:0] SIG_BYTE2 = 8'h3c, // arbitrary value
    parameter [7:0] CAL_BYTE = 8'h80
) (
    input wire clk,
    input wire rst,
    input wire load_strobe,
    input wire action_sel_1,
    input wire action_sel_0,
    input wire byte_sel_1,
    input wire byte_sel_2,
    input wire program_strobe_n,
    input wire output_enable_n,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe,
    output reg ready_busy_out,
    output reg load_ready
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DRAIN = 2'h1;
    localparam [1:0] ST_COMMIT = 2'h2;
    localparam [1:0] ST_WAIT = 2'h3;
    localparam [31:0] WAIT_FULL = WRITE_CYCLES - 1; // cut to the timer width where used
    reg [7:0] flash_lo [0:`FLASH_WORDS-1], flash_hi [0:`FLASH_WORDS-1];
    reg [7:0] eeprom [0:`EE_BYTES-1];
    reg [7:0] fbuf_lo [0:`FLASH_PAGE_WORDS-1], fbuf_hi [0:`FLASH_PAGE_WORDS-1];
    reg [7:0] ebuf [0:`EE_PAGE_BYTES-1];
    reg load_prev, prog_prev;
    reg [7:0] command, addr_lo, addr_hi, data_lo;
    reg [7:0] fuse_low, fuse_high, fuse_ext, lock_bits;
    reg [1:0] state;
    reg [3:0] copy_idx;
    reg [`TIMER_W-1:0] timer;
    reg [7:0] next_data_out;
    wire [1:0] action;
    wire load_edge, prog_edge, page_cmd, flush;
    wire fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    wire [`ENTRY_W-1:0] fifo_in_data, fifo_out_data;
    wire [5:0] flash_page;
    wire [4:0] ee_page;
    wire [`FLASH_AW-1:0] flash_addr, copy_faddr;
    wire [`EE_AW-1:0] copy_eaddr;
    wire [3:0] copy_last;

    // true when the lock byte holds lock mode 3 (both low lock bits programmed)
    function lock_mode3(input [7:0] lb);
        begin
            lock_mode3 = (lb[1:0] == 2'h0);
        end
    endfunction

    // fuse/lock select from byte_sel_2/byte_sel_1, shared by read and write
    function [1:0] fuse_sel(input bs2, input bs1);
        begin
            fuse_sel = {bs2, bs1};
        end
    endfunction

    assign action = {action_sel_1, action_sel_0};
    assign load_edge = load_strobe && !load_prev;
    assign prog_edge = !program_strobe_n && prog_prev;
    assign page_cmd = (command == `CMD_WR_FLASH) || (command == `CMD_WR_EEPROM);

    // page number takes the top bits of the low byte when pages are small
    assign flash_addr = {addr_hi[1:0], addr_lo};
    assign flash_page = flash_addr[`FLASH_AW-1:`FLASH_WORD_BITS];
    assign ee_page = addr_lo[`EE_AW-1:`EE_BYTE_BITS];
    assign copy_faddr = {flash_page, copy_idx};
    assign copy_eaddr = {ee_page, copy_idx[`EE_BYTE_BITS-1:0]};
    assign copy_last = (command == `CMD_WR_EEPROM) ? 4'h3 : 4'hf;

    // data loads under a page command travel through the fifo to the buffer
    assign fifo_in_valid = load_edge && (action == `ACT_DATA) && page_cmd;
    assign fifo_in_data = {command[0], byte_sel_1, addr_lo[3:0], data_in};
    // drain stalls while a page is being copied or burned
    assign fifo_out_ready = (state == ST_IDLE) || (state == ST_DRAIN);
    // a no-op command drops any queued but unbuffered data
    assign flush = load_edge && (action == `ACT_CMD) && !byte_sel_1
        && (data_in == `CMD_NOP);

    nvm_fifo #(
        .WIDTH(`ENTRY_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .flush(flush),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // strobe history for edge detection
    always @(posedge clk) begin
        if (rst) begin
            load_prev <= 1'b0;
            prog_prev <= 1'b1;
            load_ready <= 1'b1;
        end else begin
            load_prev <= load_strobe;
            prog_prev <= program_strobe_n;
            load_ready <= fifo_in_ready;
        end
    end

    // command, address and data latches; values stay until reloaded
    always @(posedge clk) begin
        if (rst) begin
            command <= `CMD_NOP;
            addr_lo <= 8'h00;
            addr_hi <= 8'h00;
            data_lo <= 8'h00;
        end else if (load_edge) begin
            case (action)
                `ACT_CMD: if (!byte_sel_1) command <= data_in;
                `ACT_ADDR: begin
                    if (byte_sel_1) addr_hi <= data_in;
                    else addr_lo <= data_in;
                end
                `ACT_DATA: if (!byte_sel_1) data_lo <= data_in;
                // idle action: nothing latched
                default: ;
            endcase
        end
    end

    // page buffers filled from the fifo, one word per address
    always @(posedge clk) begin
        if (fifo_out_valid && fifo_out_ready) begin
            if (fifo_out_data[13]) begin
                ebuf[fifo_out_data[9:8]] <= fifo_out_data[7:0];
            end else if (fifo_out_data[12]) begin
                fbuf_hi[fifo_out_data[11:8]] <= fifo_out_data[7:0];
            end else begin
                fbuf_lo[fifo_out_data[11:8]] <= fifo_out_data[7:0];
            end
        end
    end

    // array update during commit, one word per cycle
    always @(posedge clk) begin
        if (state == ST_COMMIT) begin
            if (command == `CMD_WR_EEPROM) begin
                eeprom[copy_eaddr] <= ebuf[copy_idx[`EE_BYTE_BITS-1:0]];
            end else begin
                flash_lo[copy_faddr] <= fbuf_lo[copy_idx];
                flash_hi[copy_faddr] <= fbuf_hi[copy_idx];
            end
        end
    end

    // write sequencer: drain queued data, commit the page, then hold busy
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            copy_idx <= 4'h0;
            timer <= {`TIMER_W{1'b0}};
            ready_busy_out <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    // strobes under read or no-op commands start nothing
                    if (prog_edge && page_cmd) begin
                        state <= ST_DRAIN;
                        ready_busy_out <= 1'b0;
                    end else if (prog_edge && ((command == `CMD_WR_FUSE)
                            || (command == `CMD_WR_LOCK))) begin
                        state <= ST_WAIT;
                        timer <= {`TIMER_W{1'b0}};
                        ready_busy_out <= 1'b0;
                    end
                end
                ST_DRAIN: begin
                    // queued words must land before the copy reads the buffer
                    if (!fifo_out_valid) begin
                        state <= ST_COMMIT;
                        copy_idx <= 4'h0;
                    end
                end
                ST_COMMIT: begin
                    if (copy_idx == copy_last) begin
                        state <= ST_WAIT;
                        timer <= {`TIMER_W{1'b0}};
                    end else begin
                        copy_idx <= copy_idx + 4'h1;
                    end
                end
                ST_WAIT: begin
                    if (timer >= WAIT_FULL[`TIMER_W-1:0]) begin
                        state <= ST_IDLE;
                        ready_busy_out <= 1'b1;
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    ready_busy_out <= 1'b1;
                end
            endcase
        end
    end

    // fuse and lock bytes, written at the start of the busy period
    always @(posedge clk) begin
        if (rst) begin
            fuse_low <= `FUSE_LOW_RST;
            fuse_high <= `FUSE_HIGH_RST;
            fuse_ext <= `FUSE_EXT_RST;
            lock_bits <= `LOCK_RST;
        end else if (state == ST_IDLE && prog_edge) begin
            if (command == `CMD_WR_FUSE) begin
                case (fuse_sel(byte_sel_2, byte_sel_1))
                    2'h0: fuse_low <= data_lo;
                    2'h1: fuse_high <= data_lo;
                    2'h2: fuse_ext <= data_lo;
                    default: ; // both selects high: no fuse byte
                endcase
            end else if (command == `CMD_WR_LOCK) begin
                // and-ing only programs bits; only reset sets them back to one
                if (lock_mode3(lock_bits)) begin
                    lock_bits <= {lock_bits[7:2], lock_bits[1:0] & data_lo[1:0]};
                end else begin
                    lock_bits <= lock_bits & data_lo;
                end
            end
        end
    end

    // read mux; registered, so data follows output enable by one cycle
    always @* begin
        next_data_out = `BLANK_BYTE;
        case (command)
            `CMD_RD_FLASH: begin
                next_data_out = byte_sel_1 ? flash_hi[flash_addr]
                    : flash_lo[flash_addr];
            end
            `CMD_RD_EEPROM: begin
                if (!byte_sel_1) next_data_out = eeprom[addr_lo[`EE_AW-1:0]];
            end
            `CMD_RD_FUSE: begin
                case (fuse_sel(byte_sel_2, byte_sel_1))
                    2'h0: next_data_out = fuse_low;
                    2'h3: next_data_out = fuse_high;
                    2'h2: next_data_out = fuse_ext;
                    default: next_data_out = lock_bits;
                endcase
            end
            `CMD_RD_SIG: begin
                if (byte_sel_1) begin
                    if (addr_lo == `CAL_ADDR) next_data_out = CAL_BYTE;
                end else begin
                    case (addr_lo)
                        8'h00: next_data_out = SIG_BYTE0;
                        8'h01: next_data_out = SIG_BYTE1;
                        `SIG_LAST: next_data_out = SIG_BYTE2;
                        default: next_data_out = `BLANK_BYTE;
                    endcase
                end
            end
            default: next_data_out = `BLANK_BYTE;
        endcase
    end

    // bus driven while output enable is low, one cycle late
    always @(posedge clk) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_out <= next_data_out;
            data_oe <= !output_enable_n;
        end
    end
endmodule

`default_nettype wire

// *** tb/nvm_port_properties.sv ***
// checker for the programming port, watching its pins only
// assumes one clock and a synchronous active-high reset
`default_nettype none
module nvm_port_properties #(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_strobe,
    input wire logic action_sel_1,
    input wire logic action_sel_0,
    input wire logic byte_sel_1,
    input wire logic byte_sel_2,
    input wire logic program_strobe_n,
    input wire logic output_enable_n,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_out,
    input wire logic load_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ls_q;
    logic wr_q;
    logic [7:0] cmd;
    logic [8:0] cnt;
    wire wr_fall = wr_q && !program_strobe_n;
    wire page_cmd = cmd == 8'h10 || cmd == 8'h11;
    wire nv_cmd = cmd == 8'h40 || cmd == 8'h20;

    // shadow of the loaded command and a count of busy cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            ls_q <= 1'b0;
            wr_q <= 1'b1;
            cmd <= 8'h00;
            cnt <= 9'h000;
        end else begin
            ls_q <= load_strobe;
            wr_q <= program_strobe_n;
            if (load_strobe && !ls_q && action_sel_1 && !action_sel_0 && !byte_sel_1) begin
                cmd <= data_in;
            end
            cnt <= ready_busy_out ? 9'h000 : cnt + 9'h001;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    AST_BUS_OFF: assert property (
        output_enable_n |=> !data_oe) else $error("bus driven with reads off");
    AST_BUS_ON: assert property (
        !output_enable_n |=> data_oe) else $error("bus not driven in a read");
    AST_BUSY_START: assert property (
        wr_fall && ready_busy_out && (page_cmd || nv_cmd) |=> !ready_busy_out)
        else $error("write strobe gave no busy");
    AST_NO_WRITE: assert property (
        wr_fall && ready_busy_out && !page_cmd && !nv_cmd |=> ready_busy_out [*4])
        else $error("busy without a write command");
    AST_BUSY_HOLD: assert property (
        $fell(ready_busy_out) |-> !ready_busy_out [*8]) else $error("busy too short");
    AST_NV_TIME: assert property (
        $rose(ready_busy_out) && nv_cmd |-> cnt == 9'(WRITE_CYCLES))
        else $error("fuse or lock write time wrong");
    AST_PAGE_TIME: assert property (
        $rose(ready_busy_out) && page_cmd |-> cnt > 9'(WRITE_CYCLES + (cmd[0] ? 4 : 16)))
        else $error("page write ended too early");
    AST_BUSY_MAX: assert property (
        !ready_busy_out |-> cnt < 9'h0c8) else $error("write never completed");
    AST_AFTER_RESET: assert property (
        $fell(rst) |-> ready_busy_out && load_ready && !data_oe)
        else $error("wrong levels after reset");

    COV_PAGE: cover property ($rose(ready_busy_out) && page_cmd);
    COV_NV: cover property ($rose(ready_busy_out) && nv_cmd);
    COV_FULL: cover property (!load_ready);
endmodule

bind nvm_port nvm_port_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props (
    .clk(clk), .rst(rst), .load_strobe(load_strobe), .action_sel_1(action_sel_1),
    .action_sel_0(action_sel_0), .byte_sel_1(byte_sel_1), .byte_sel_2(byte_sel_2),
    .program_strobe_n(program_strobe_n), .output_enable_n(output_enable_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_out(ready_busy_out), .load_ready(load_ready)
);
`default_nettype wire

// *** tb/nvm_programmer.sv ***
// model of the external programmer driving the port's pins
// assumes pins change on the falling clock edge, sampled on the rising
`default_nettype none
module nvm_programmer (
    input wire logic clk,
    input wire logic ready,
    input wire logic [7:0] dev_data,
    input wire logic dev_oe,
    output logic [7:0] data_in,
    output logic load_strobe,
    output logic action_sel_1,
    output logic action_sel_0,
    output logic byte_sel_1,
    output logic byte_sel_2,
    output logic program_strobe_n,
    output logic output_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv = 8'h00;
    logic drv_en = 1'b1;

    // released bus shows the inverse of the last value, never a stale copy
    assign data_in = dev_oe ? dev_data : drv_en ? drv : ~drv;

    // idle pin levels from time zero
    initial begin
        load_strobe = 1'b0;
        {action_sel_1, action_sel_0} = 2'h3;
        byte_sel_1 = 1'b0;
        byte_sel_2 = 1'b0;
        program_strobe_n = 1'b1;
        output_enable_n = 1'b1;
    end

    // levels set a cycle before the positive pulse and held past it
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        @(negedge clk);
        {action_sel_1, action_sel_0} = act;
        byte_sel_1 = bs1;
        drv = d;
        drv_en = 1'b1;
        @(negedge clk);
        load_strobe = 1'b1;
        @(negedge clk);
        load_strobe = 1'b0;
    endtask

    // selects settle first, then one low cycle on the write strobe
    task automatic pulse_wr(input logic bs2, input logic bs1, output logic rdy);
        @(negedge clk);
        byte_sel_2 = bs2;
        byte_sel_1 = bs1;
        @(negedge clk);
        program_strobe_n = 1'b0;
        @(negedge clk);
        rdy = ready;
        program_strobe_n = 1'b1;
    endtask

    // selects held until ready returns; bounded so a hang is seen
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        byte_sel_1 = 1'b0;
        byte_sel_2 = 1'b0;
    endtask

    // bus handed over for the read, taken back once the device lets go
    task automatic read(input logic bs2, input logic bs1, output logic [7:0] d);
        @(negedge clk);
        byte_sel_2 = bs2;
        byte_sel_1 = bs1;
        drv_en = 1'b0;
        output_enable_n = 1'b0;
        @(negedge clk);
        @(negedge clk);
        d = data_in;
        output_enable_n = 1'b1;
        @(negedge clk);
        drv_en = 1'b1;
        byte_sel_1 = 1'b0;
        byte_sel_2 = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/nvm_port_tb_top.sv ***
// self-checking bench for the programming port with a programmer model
// assumes the design sources and the defines header are compiled first
`default_nettype none
`include "nvm_port_defines.vh"
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module nvm_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 20;
    localparam logic [7:0] S0 = 8'h21; // arbitrary value
    localparam logic [7:0] S1 = 8'h43; // arbitrary value
    localparam logic [7:0] S2 = 8'h65; // arbitrary value
    localparam logic [7:0] CAL = 8'h87; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    int miscompares = 0;
    int tests_run = 0;
    wire load_strobe, action_sel_1, action_sel_0, byte_sel_1, byte_sel_2;
    wire program_strobe_n, output_enable_n, data_oe, ready_busy_out, load_ready;
    wire [7:0] data_in;
    wire [7:0] data_out;

    always #4 clk = ~clk;

    nvm_programmer prog (.clk(clk), .ready(ready_busy_out), .dev_data(data_out),
        .dev_oe(data_oe), .data_in(data_in), .load_strobe(load_strobe),
        .action_sel_1(action_sel_1), .action_sel_0(action_sel_0), .byte_sel_1(byte_sel_1),
        .byte_sel_2(byte_sel_2), .program_strobe_n(program_strobe_n),
        .output_enable_n(output_enable_n));

    nvm_port #(.WRITE_CYCLES(WC), .SIG_BYTE0(S0), .SIG_BYTE1(S1), .SIG_BYTE2(S2),
        .CAL_BYTE(CAL)) uut (.clk(clk), .rst(rst), .load_strobe(load_strobe),
        .action_sel_1(action_sel_1), .action_sel_0(action_sel_0), .byte_sel_1(byte_sel_1),
        .byte_sel_2(byte_sel_2), .program_strobe_n(program_strobe_n),
        .output_enable_n(output_enable_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .ready_busy_out(ready_busy_out), .load_ready(load_ready));

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 37 + 11);
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a used-up wait bound ends the run
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            give_verdict();
        end
    endtask

    // start a write, expect busy at once, wait for ready
    task automatic wr(input logic bs2, input logic bs1);
        logic r;
        int n;
        prog.pulse_wr(bs2, bs1, r);
        `CHK("busy", 1'b0, r)
        prog.wait_ready(n);
        bound(n, 500);
    endtask

    task automatic rd(input string nm, input logic bs2, input logic bs1, input logic [7:0] e);
        logic [7:0] d;
        prog.read(bs2, bs1, d);
        `CHK(nm, e, d)
    endtask

    task automatic t_reset();
        `CHK("ready", 1'b1, ready_busy_out)
        `CHK("room", 1'b1, load_ready)
        prog.load(2'h2, 1'b0, 8'h04);
        rd("fuse_low", 1'b0, 1'b0, `FUSE_LOW_RST);
        rd("fuse_high", 1'b1, 1'b1, `FUSE_HIGH_RST);
        rd("fuse_ext", 1'b1, 1'b0, `FUSE_EXT_RST);
        rd("lock", 1'b0, 1'b1, `LOCK_RST);
        $display("test reset done");
    endtask

    // top page of flash: page bits sit in the upper address low nibble and in address high bits 1:0
    task automatic t_flash();
        prog.load(2'h2, 1'b0, 8'h10);
        prog.load(2'h0, 1'b1, 8'h03);
        for (int i = 0; i < 16; i++) begin
            prog.load(2'h0, 1'b0, {4'hf, i[3:0]});
            prog.load(2'h1, 1'b0, pat(i));
            prog.load(2'h1, 1'b1, ~pat(i));
        end
        wr(1'b0, 1'b0);
        prog.load(2'h2, 1'b0, 8'h00);
        prog.load(2'h2, 1'b0, 8'h02);
        for (int i = 0; i < 16; i++) begin
            prog.load(2'h0, 1'b0, {4'hf, i[3:0]});
            rd("flash_lo", 1'b0, 1'b0, pat(i));
            rd("flash_hi", 1'b0, 1'b1, ~pat(i));
        end
        $display("test flash done");
    endtask

    task automatic t_eeprom();
        prog.load(2'h2, 1'b0, 8'h11);
        prog.load(2'h0, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            prog.load(2'h0, 1'b0, 8'h7c + i[7:0]);
            prog.load(2'h1, 1'b0, pat(i + 40));
        end
        wr(1'b0, 1'b0);
        prog.load(2'h2, 1'b0, 8'h03);
        for (int i = 0; i < 4; i++) begin
            prog.load(2'h0, 1'b0, 8'h7c + i[7:0]);
            rd("eeprom", 1'b0, 1'b0, pat(i + 40));
        end
        $display("test eeprom done");
    endtask

    // write selects k = {bs2,bs1}: 0 low, 1 high, 2 extended
    task automatic t_fuse();
        logic [7:0] v;
        for (int k = 0; k < 3; k++) begin
            v = 8'hc3 - 8'(k * 33);
            prog.load(2'h2, 1'b0, 8'h40);
            prog.load(2'h1, 1'b0, v);
            wr(k[1], k[0]);
            prog.load(2'h2, 1'b0, 8'h04);
            rd("fuse", k[1] | k[0], k[0], v);
        end
        rd("fuse_low_kept", 1'b0, 1'b0, 8'hc3);
        $display("test fuse done");
    endtask

    // first write enters mode 3; later writes must leave the bits alone
    task automatic t_lock();
        prog.load(2'h2, 1'b0, 8'h20);
        prog.load(2'h1, 1'b0, 8'hec);
        wr(1'b0, 1'b0);
        prog.load(2'h1, 1'b0, 8'h0d);
        wr(1'b0, 1'b0);
        prog.load(2'h1, 1'b0, 8'hff);
        wr(1'b0, 1'b0);
        prog.load(2'h2, 1'b0, 8'h04);
        rd("lock", 1'b0, 1'b1, 8'hec);
        $display("test lock done");
    endtask

    task automatic t_sig();
        logic r;
        prog.load(2'h2, 1'b0, 8'h08);
        for (int a = 0; a < 4; a++) begin
            prog.load(2'h0, 1'b0, a[7:0]);
            rd("sig", 1'b0, 1'b0, a == 0 ? S0 : a == 1 ? S1 : a == 2 ? S2 : 8'hff);
        end
        prog.load(2'h0, 1'b0, 8'h00);
        rd("cal", 1'b0, 1'b1, CAL);
        prog.load(2'h3, 1'b0, 8'h01);
        prog.load(2'h3, 1'b1, 8'h99);
        rd("idle_load", 1'b0, 1'b0, S0);
        prog.pulse_wr(1'b0, 1'b0, r);
        `CHK("no_busy", 1'b1, r)
        $display("test signature done");
    endtask

    // page data loaded while a write runs: the buffer fills, refuses, then drains
    task automatic t_fifo();
        logic r;
        int n;
        prog.load(2'h2, 1'b0, 8'h10);
        prog.pulse_wr(1'b0, 1'b0, r);
        for (int i = 0; i < 9; i++) begin
            prog.load(2'h1, 1'b0, pat(i));
        end
        repeat (2) @(negedge clk);
        `CHK("full", 1'b0, load_ready)
        prog.wait_ready(n);
        bound(n, 500);
        n = 0;
        while (load_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        bound(n, 50);
        `CHK("drained", 1'b1, load_ready)
        prog.load(2'h2, 1'b0, 8'h00);
        $display("test buffer done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_flash();
        t_eeprom();
        t_fuse();
        t_lock();
        t_sig();
        t_fifo();
        give_verdict();
    end
endmodule
`default_nettype wire
